// ### design/sha_engine_map.vh
// Purpose: Register offsets, field codes, reset values and counts of the hash engine
// Assumes: Byte addresses on an 8-bit register address port, one 32-bit word each
// Notes:   Definitions only
`ifndef SHA_ENGINE_MAP_VH
`define SHA_ENGINE_MAP_VH

// Register byte offsets
`define SHA_OFF_ALG_SEL      8'h00
`define SHA_OFF_BLOCK_CNT    8'h0C
`define SHA_OFF_START        8'h10
`define SHA_OFF_CONTINUE     8'h14
`define SHA_OFF_BUSY         8'h18
`define SHA_OFF_DMA_START    8'h1C
`define SHA_OFF_DMA_CONTINUE 8'h20
`define SHA_OFF_IRQ_CLEAR    8'h24
`define SHA_OFF_IRQ_ENABLE   8'h28
`define SHA_OFF_VERSION      8'h2C
`define SHA_OFF_HASH_BASE    8'h40
`define SHA_OFF_MSG_BASE     8'h80

// Algorithm select codes
`define SHA_ALG_SHA1         2'h0
`define SHA_ALG_SHA224       2'h1
`define SHA_ALG_SHA256       2'h2

// Round counts and block geometry
`define SHA_ROUNDS_SHA1      7'h50
`define SHA_ROUNDS_SHA2      7'h40
`define SHA_WORDS_PER_BLOCK  5'h10
`define SHA_BLOCK_CNT_MAX    6'h3F

// Reset values
`define SHA_RST_ALG          2'h0
`define SHA_RST_BLOCK_CNT    6'h00
`define SHA_RST_WORD         32'h0000_0000

// Initial hash constants, SHA-1
`define SHA_IV1_0 32'h6745_2301
`define SHA_IV1_1 32'hEFCD_AB89
`define SHA_IV1_2 32'h98BA_DCFE
`define SHA_IV1_3 32'h1032_5476
`define SHA_IV1_4 32'hC3D2_E1F0

// Initial hash constants, SHA-224
`define SHA_IV224 {32'hC105_9ED8, 32'h367C_D507, 32'h3070_DD17, 32'hF70E_5939, \
                   32'hFFC0_0B31, 32'h6858_1511, 32'h64F9_8FA7, 32'hBEFA_4FA4}

// Initial hash constants, SHA-256
`define SHA_IV256 {32'h6A09_E667, 32'hBB67_AE85, 32'h3C6E_F372, 32'hA54F_F53A, \
                   32'h510E_527F, 32'h9B05_688C, 32'h1F83_D9AB, 32'h5BE0_CD19}

// SHA-1 round constants
`define SHA_K1_0 32'h5A82_7999
`define SHA_K1_1 32'h6ED9_EBA1
`define SHA_K1_2 32'h8F1B_BCDC
`define SHA_K1_3 32'hCA62_C1D6

`endif

// ### design/sha_engine.v
// Purpose: SHA-1 / SHA-224 / SHA-256 block engine with processor-fed and DMA-fed modes
// Assumes: Register port and DMA word port run on clk; one round per clock
// Notes:   Message words are snapshotted at launch so the next block may be prefetched
`timescale 1ns/1ps
`default_nettype none
`include "sha_engine_map.vh"

// Summary of operation
// RL1 - Two modes: processor writes blocks via registers, or DMA supplies blocks.
// RL2 - Writing 1 to start launches processor mode; DMA-start launches DMA mode.
// RL3 - Algorithm select: 0 is SHA-1, 1 is SHA-224, 2 is SHA-256.
// RL4 - Only whole 512-bit blocks are hashed; no padding in hardware.
// RL5 - Software pads: one bit, zeros to 448 mod 512, 64-bit length.
// RL6 - Block is sixteen 32-bit words; word 0 into message register 0 onward.
// RL7 - Start launch begins from hardware initial constants of the selected algorithm.
// RL8 - Continue launch begins from the values currently in the hash registers.
// RL9 - Busy reads nonzero while a block runs, zero once idle again.
// RL10 - Message registers may be rewritten during a run without harming it.
// RL11 - Hash registers show the digest after each operation and are writable.
// RL12 - Interleaving allowed per block in processor mode, per DMA run otherwise.
// RL13 - Software saves algorithm and hash, runs other job, restores, then continues.
// RL14 - Processor mode: select, then per block write, launch, poll idle; read digest.
// RL15 - Completion interrupt only for DMA-fed runs; processor runs use busy only.
// RL16 - One DMA run takes a block count of at most 63 from its register.
// RL17 - Digest fills hash words from index 0: five, seven or eight words.
// RL18 - DMA interrupt raised only if enabled; held until clear register gets 1.
// RL19 - Busy sets the cycle after a launch write and holds until write-back.
// RL20 - Algorithm and hash writes during a run are ignored; message writes allowed.
module sha_engine
#(
   parameter [31:0] VERSION = 32'h0000_0001  // Arbitrary version value
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata_r,
   // DMA word port
   output reg         dma_req_r,
   input  wire        dma_valid,
   input  wire [31:0] dma_data,
   // Completion and status
   output reg         dma_done_irq_r,
   output reg         busy_r
);

   localparam [3:0] ST_IDLE   = 4'h1;
   localparam [3:0] ST_FETCH  = 4'h2;
   localparam [3:0] ST_ROUND  = 4'h4;
   localparam [3:0] ST_UPDATE = 4'h8;

   localparam [2047:0] K256_TAB = {
      32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5, 32'h3956C25B, 32'h59F111F1,
      32'h923F82A4, 32'hAB1C5ED5, 32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
      32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174, 32'hE49B69C1, 32'hEFBE4786,
      32'h0FC19DC6, 32'h240CA1CC, 32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
      32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7, 32'hC6E00BF3, 32'hD5A79147,
      32'h06CA6351, 32'h14292967, 32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
      32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85, 32'hA2BFE8A1, 32'hA81A664B,
      32'hC24B8B70, 32'hC76C51A3, 32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
      32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5, 32'h391C0CB3, 32'h4ED8AA4A,
      32'h5B9CCA4F, 32'h682E6FF3, 32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
      32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};

   localparam [255:0] IV224 = `SHA_IV224;
   localparam [255:0] IV256 = `SHA_IV256;

   // Hardware initial constant for one digest word
   function [31:0] init_const;
      input [1:0] alg;
      input [2:0] idx;
      begin
         init_const = `SHA_RST_WORD;
         case (alg)
            `SHA_ALG_SHA224:
            begin
               init_const = IV224[{~idx, 5'h00} +: 32];
            end
            `SHA_ALG_SHA256:
            begin
               init_const = IV256[{~idx, 5'h00} +: 32];
            end
            default:
            begin
               case (idx)
                  3'h0:    init_const = `SHA_IV1_0;
                  3'h1:    init_const = `SHA_IV1_1;
                  3'h2:    init_const = `SHA_IV1_2;
                  3'h3:    init_const = `SHA_IV1_3;
                  3'h4:    init_const = `SHA_IV1_4;
                  default: init_const = `SHA_RST_WORD;
               endcase
            end
         endcase
      end
   endfunction

   // Register address match
   function is_reg;
      input [7:0] addr;
      input [7:0] off;
      begin
         is_reg = (addr == off);
      end
   endfunction

   reg  [3:0]  state_r;
   reg  [1:0]  alg_r;
   reg  [5:0]  blk_cnt_r;
   reg  [5:0]  blk_left_r;
   reg         dma_mode_r;
   reg         use_iv_r;
   reg  [4:0]  fetch_cnt_r;
   reg  [6:0]  rnd_r;
   reg         irq_en_r;
   reg  [31:0] hash_r  [0:7];
   reg  [31:0] msg_r   [0:15];
   reg  [31:0] sched_r [0:15];
   reg  [31:0] work_r  [0:7];
   integer     i;
   integer     j;

   wire        is_sha1   = (alg_r == `SHA_ALG_SHA1);
   wire [6:0]  last_rnd  = is_sha1 ? (`SHA_ROUNDS_SHA1 - 7'h01) : (`SHA_ROUNDS_SHA2 - 7'h01);
   wire        idle      = (state_r == ST_IDLE);
   wire        wr_start  = reg_wr & is_reg(reg_addr, `SHA_OFF_START);
   wire        wr_cont   = reg_wr & is_reg(reg_addr, `SHA_OFF_CONTINUE);
   wire        wr_dstart = reg_wr & is_reg(reg_addr, `SHA_OFF_DMA_START);
   wire        wr_dcont  = reg_wr & is_reg(reg_addr, `SHA_OFF_DMA_CONTINUE);
   wire        wr_hash   = reg_wr & (reg_addr[7:5] == 3'h2) & idle;  // see RL20
   wire        launch_cpu = idle & reg_wdata[0] & (wr_start | wr_cont);   // see RL2
   wire        launch_dma = idle & reg_wdata[0] & (wr_dstart | wr_dcont); // see RL2
   wire        dma_take  = dma_req_r & dma_valid;
   wire        fetch_end = dma_take & (fetch_cnt_r == (`SHA_WORDS_PER_BLOCK - 5'h01));

   // Working variables
   wire [31:0] va = work_r[0];
   wire [31:0] vb = work_r[1];
   wire [31:0] vc = work_r[2];
   wire [31:0] vd = work_r[3];
   wire [31:0] ve = work_r[4];
   wire [31:0] vf = work_r[5];
   wire [31:0] vg = work_r[6];
   wire [31:0] vh = work_r[7];
   wire [31:0] wt = sched_r[0];

   // SHA-256 round
   wire [31:0] big_s0 = {va[1:0], va[31:2]} ^ {va[12:0], va[31:13]} ^ {va[21:0], va[31:22]};
   wire [31:0] big_s1 = {ve[5:0], ve[31:6]} ^ {ve[10:0], ve[31:11]} ^ {ve[24:0], ve[31:25]};
   wire [31:0] ch     = (ve & vf) ^ (~ve & vg);
   wire [31:0] maj    = (va & vb) ^ (va & vc) ^ (vb & vc);
   wire [31:0] k256   = K256_TAB[{~rnd_r[5:0], 5'h00} +: 32];
   wire [31:0] t1     = vh + big_s1 + ch + k256 + wt;
   wire [31:0] t2     = big_s0 + maj;

   // SHA-1 round
   reg  [31:0] f1;
   reg  [31:0] k1;
   always @*
   begin
      if (rnd_r < 7'h14)
      begin
         f1 = (vb & vc) | (~vb & vd);
         k1 = `SHA_K1_0;
      end
      else if (rnd_r < 7'h28)
      begin
         f1 = vb ^ vc ^ vd;
         k1 = `SHA_K1_1;
      end
      else if (rnd_r < 7'h3C)
      begin
         f1 = (vb & vc) | (vb & vd) | (vc & vd);
         k1 = `SHA_K1_2;
      end
      else
      begin
         f1 = vb ^ vc ^ vd;
         k1 = `SHA_K1_3;
      end
   end
   wire [31:0] t_sha1 = {va[26:0], va[31:27]} + f1 + ve + k1 + wt;

   // Next schedule word
   wire [31:0] x1    = sched_r[13] ^ sched_r[8] ^ sched_r[2] ^ sched_r[0];
   wire [31:0] w1    = sched_r[1];
   wire [31:0] w14   = sched_r[14];
   wire [31:0] sm0   = {w1[6:0], w1[31:7]} ^ {w1[17:0], w1[31:18]} ^ {3'h0, w1[31:3]};
   wire [31:0] sm1   = {w14[16:0], w14[31:17]} ^ {w14[18:0], w14[31:19]} ^ {10'h000, w14[31:10]};
   wire [31:0] w_nxt = is_sha1 ? {x1[30:0], x1[31]} : (sm1 + sched_r[9] + sm0 + sched_r[0]);

   // Software-visible configuration
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         alg_r     <= `SHA_RST_ALG;
         blk_cnt_r <= `SHA_RST_BLOCK_CNT;
         irq_en_r  <= 1'b0;
      end
      else if (reg_wr)
      begin
         if (is_reg(reg_addr, `SHA_OFF_ALG_SEL) && idle)
            alg_r <= reg_wdata[1:0];                      // see RL3 RL20
         if (is_reg(reg_addr, `SHA_OFF_BLOCK_CNT) && idle)
            blk_cnt_r <= reg_wdata[5:0] & `SHA_BLOCK_CNT_MAX; // see RL16
         if (is_reg(reg_addr, `SHA_OFF_IRQ_ENABLE))
            irq_en_r <= reg_wdata[0];
      end
   end

   // Message registers, writable at any time
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (j = 0; j < 16; j = j + 1)
            msg_r[j] <= `SHA_RST_WORD;
      end
      else if (reg_wr && reg_addr[7:6] == 2'h2)
      begin
         msg_r[reg_addr[5:2]] <= reg_wdata;               // see RL6 RL10
      end
   end

   // Engine
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r     <= ST_IDLE;
         busy_r      <= 1'b0;
         dma_req_r   <= 1'b0;
         dma_mode_r  <= 1'b0;
         use_iv_r    <= 1'b0;
         blk_left_r  <= 6'h00;
         fetch_cnt_r <= 5'h00;
         rnd_r       <= 7'h00;
         for (i = 0; i < 16; i = i + 1)
            sched_r[i] <= `SHA_RST_WORD;
         for (i = 0; i < 8; i = i + 1)
         begin
            hash_r[i] <= `SHA_RST_WORD;
            work_r[i] <= `SHA_RST_WORD;
         end
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (wr_hash)
                  hash_r[reg_addr[4:2]] <= reg_wdata;     // see RL11
               if (launch_cpu)
               begin
                  busy_r     <= 1'b1;                     // see RL19 RL9
                  dma_mode_r <= 1'b0;                     // see RL1
                  rnd_r      <= 7'h00;
                  state_r    <= ST_ROUND;
                  for (i = 0; i < 16; i = i + 1)
                     sched_r[i] <= msg_r[i];              // see RL10 RL4
                  for (i = 0; i < 8; i = i + 1)
                  begin
                     if (wr_start)
                     begin
                        hash_r[i] <= init_const(alg_r, i[2:0]); // see RL7
                        work_r[i] <= init_const(alg_r, i[2:0]);
                     end
                     else
                        work_r[i] <= hash_r[i];           // see RL8
                  end
               end
               else if (launch_dma && blk_cnt_r != 6'h00)
               begin
                  busy_r      <= 1'b1;                    // see RL19
                  dma_mode_r  <= 1'b1;                    // see RL1
                  use_iv_r    <= wr_dstart;
                  blk_left_r  <= blk_cnt_r;               // see RL16
                  fetch_cnt_r <= 5'h00;
                  dma_req_r   <= 1'b1;
                  state_r     <= ST_FETCH;
               end
            end
            ST_FETCH:
            begin
               if (dma_take)
               begin
                  sched_r[fetch_cnt_r[3:0]] <= dma_data;  // see RL6
                  fetch_cnt_r <= fetch_cnt_r + 5'h01;
               end
               if (fetch_end)
               begin
                  dma_req_r <= 1'b0;
                  use_iv_r  <= 1'b0;
                  rnd_r     <= 7'h00;
                  state_r   <= ST_ROUND;
                  for (i = 0; i < 8; i = i + 1)
                  begin
                     if (use_iv_r)
                     begin
                        hash_r[i] <= init_const(alg_r, i[2:0]); // see RL7
                        work_r[i] <= init_const(alg_r, i[2:0]);
                     end
                     else
                        work_r[i] <= hash_r[i];           // see RL8
                  end
               end
            end
            ST_ROUND:
            begin
               for (i = 0; i < 15; i = i + 1)
                  sched_r[i] <= sched_r[i + 1];
               sched_r[15] <= w_nxt;
               if (is_sha1)
               begin
                  work_r[0] <= t_sha1;
                  work_r[1] <= va;
                  work_r[2] <= {vb[1:0], vb[31:2]};
                  work_r[3] <= vc;
                  work_r[4] <= vd;
               end
               else
               begin
                  work_r[0] <= t1 + t2;
                  work_r[1] <= va;
                  work_r[2] <= vb;
                  work_r[3] <= vc;
                  work_r[4] <= vd + t1;
                  work_r[5] <= ve;
                  work_r[6] <= vf;
                  work_r[7] <= vg;
               end
               rnd_r <= rnd_r + 7'h01;
               if (rnd_r == last_rnd)
                  state_r <= ST_UPDATE;
            end
            ST_UPDATE:
            begin
               for (i = 0; i < 8; i = i + 1)
               begin
                  if (!is_sha1 || i < 5)
                     hash_r[i] <= hash_r[i] + work_r[i];  // see RL17 RL11
               end
               if (dma_mode_r && blk_left_r != 6'h01)
               begin
                  blk_left_r  <= blk_left_r - 6'h01;      // see RL12
                  fetch_cnt_r <= 5'h00;
                  dma_req_r   <= 1'b1;
                  state_r     <= ST_FETCH;
               end
               else
               begin
                  busy_r     <= 1'b0;                     // see RL9 RL19
                  blk_left_r <= 6'h00;
                  state_r    <= ST_IDLE;
               end
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // DMA completion interrupt, set wins over clear
   wire dma_done = (state_r == ST_UPDATE) & dma_mode_r & (blk_left_r == 6'h01);
   wire irq_clr  = reg_wr & is_reg(reg_addr, `SHA_OFF_IRQ_CLEAR) & reg_wdata[0];
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         dma_done_irq_r <= 1'b0;
      else if (dma_done && irq_en_r)
         dma_done_irq_r <= 1'b1;                          // see RL15 RL18
      else if (irq_clr)
         dma_done_irq_r <= 1'b0;                          // see RL18
   end

   // Read data, one cycle after the read strobe
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata_r <= `SHA_RST_WORD;
      else if (reg_rd)
      begin
         if (reg_addr[7:5] == 3'h2)
            reg_rdata_r <= hash_r[reg_addr[4:2]];         // see RL11 RL17
         else if (reg_addr[7:6] == 2'h2)
            reg_rdata_r <= msg_r[reg_addr[5:2]];
         else if (is_reg(reg_addr, `SHA_OFF_ALG_SEL))
            reg_rdata_r <= {30'h0000_0000, alg_r};
         else if (is_reg(reg_addr, `SHA_OFF_BLOCK_CNT))
            reg_rdata_r <= {26'h000_0000, blk_cnt_r};
         else if (is_reg(reg_addr, `SHA_OFF_BUSY))
            reg_rdata_r <= {31'h0000_0000, busy_r};       // see RL9
         else if (is_reg(reg_addr, `SHA_OFF_IRQ_ENABLE))
            reg_rdata_r <= {31'h0000_0000, irq_en_r};
         else if (is_reg(reg_addr, `SHA_OFF_VERSION))
            reg_rdata_r <= VERSION;
         else
            reg_rdata_r <= `SHA_RST_WORD;
      end
      else
         reg_rdata_r <= `SHA_RST_WORD;
   end

endmodule // sha_engine
`default_nettype wire

// ### testbench/sha_dma_src.sv
// Purpose: DMA word source feeding one padded block per request run
// Assumes: Words are offered only while the engine requests them
// Notes:   Data shows the inverse of the last word while nothing is offered
`timescale 1ns/1ps
`default_nettype none
module sha_dma_src
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Engine side
   input  wire logic        dma_req_r,
   output logic             dma_valid,
   output logic [31:0]      dma_data,
   // Bench control
   input  wire logic        slow
);
   logic [3:0]  idx_r;
   logic        gap_r;
   logic [31:0] last_r;
   logic [31:0] word;

   // Padded one-block message, word 0 first
   assign word      = (idx_r == 4'h0) ? 32'h6162_6380 :
                      (idx_r == 4'hF) ? 32'h0000_0018 : 32'h0000_0000;
   assign dma_valid = dma_req_r & ~gap_r;
   assign dma_data  = dma_valid ? word : ~last_r;

   // Sixteen words make one whole block
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         idx_r  <= 4'h0;
         gap_r  <= 1'b0;
         last_r <= 32'h0000_0000;
      end
      else if (dma_valid)
      begin
         idx_r  <= idx_r + 4'h1;
         last_r <= word;
         gap_r  <= slow;
      end
      else
         gap_r  <= 1'b0;
   end
endmodule // sha_dma_src
`default_nettype wire

// ### testbench/sha_engine_assertions.sv
// Purpose: Port-level checks of the hash engine
// Assumes: Single clock domain, reset asynchronous active high
// Notes:   Bound to the engine after the module
`timescale 1ns/1ps
`default_nettype none
`include "sha_engine_map.vh"
module sha_engine_assertions
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_rdata_r,
   // DMA and status
   input  wire logic        dma_req_r,
   input  wire logic        dma_valid,
   input  wire logic [31:0] dma_data,
   input  wire logic        dma_done_irq_r,
   input  wire logic        busy_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [11:0] bcnt_r;
   logic [4:0]  takes_r;
   logic        typ_r;
   logic        clr_w;

   assign clr_w = reg_wr && reg_addr == `SHA_OFF_IRQ_CLEAR && reg_wdata[0];

   // Busy length, launch kind and fetch count trackers
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bcnt_r  <= 12'h000;
         takes_r <= 5'h00;
         typ_r   <= 1'b0;
      end
      else
      begin
         bcnt_r  <= busy_r ? bcnt_r + 12'h001 : 12'h000;
         takes_r <= !dma_req_r ? 5'h00 : (dma_valid ? takes_r + 5'h01 : takes_r);
         if (reg_wr && reg_wdata[0] && !busy_r)
         begin
            if (reg_addr == `SHA_OFF_START || reg_addr == `SHA_OFF_CONTINUE)
               typ_r <= 1'b1;
            else if (reg_addr == `SHA_OFF_DMA_START || reg_addr == `SHA_OFF_DMA_CONTINUE)
               typ_r <= 1'b0;
         end
      end
   end

   sequence s_typ_launch;
      reg_wr && reg_wdata[0] && !busy_r &&
      (reg_addr == `SHA_OFF_START || reg_addr == `SHA_OFF_CONTINUE);
   endsequence

   sequence s_typ_finish;
      $fell(busy_r) && typ_r;
   endsequence

   chk_busy_after_launch: assert property (s_typ_launch |=> busy_r)
      else $error("busy not set after launch");
   chk_busy_run_length: assert property (s_typ_finish |->
      (bcnt_r == 12'h041 || bcnt_r == 12'h051))
      else $error("busy length wrong");
   chk_no_typ_irq: assert property (s_typ_finish |-> !$rose(dma_done_irq_r))
      else $error("irq raised by processor-fed run");
   chk_irq_at_finish: assert property ($rose(dma_done_irq_r) |-> $fell(busy_r))
      else $error("irq rose away from completion");
   chk_irq_sticky: assert property (dma_done_irq_r && !clr_w |=> dma_done_irq_r)
      else $error("irq dropped without clear");
   chk_irq_clear: assert property (clr_w && !busy_r |=> !dma_done_irq_r)
      else $error("irq not cleared");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0000_0000)
      else $error("read data outside read cycle");
   chk_busy_reg_read: assert property (reg_rd && reg_addr == `SHA_OFF_BUSY |=>
      ((reg_rdata_r != 32'h0000_0000) == $past(busy_r)))
      else $error("busy register mismatch");
   chk_fetch_whole: assert property ($fell(dma_req_r) |-> takes_r == 5'h10)
      else $error("fetch not sixteen words");
   chk_req_in_run: assert property (dma_req_r |-> busy_r)
      else $error("request while idle");

   cov_dma_irq: cover property ($rose(dma_done_irq_r));
endmodule // sha_engine_assertions

bind sha_engine sha_engine_assertions sha_engine_assertions_inst
(
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .dma_req_r(dma_req_r),
   .dma_valid(dma_valid), .dma_data(dma_data), .dma_done_irq_r(dma_done_irq_r),
   .busy_r(busy_r)
);
`default_nettype wire

// ### testbench/sha_engine_tb.sv
// Purpose: Self-checking bench of the hash engine
// Assumes: 25 MHz clock, one padded three-byte message block
// Notes:   Rows cover each algorithm; hand tests cover continue, DMA and reset
`timescale 1ns/1ps
`default_nettype none
`include "sha_engine_map.vh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module sha_engine_tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        slow = 1'b0;
   logic [31:0] reg_rdata_r;
   logic [31:0] dma_data;
   logic        dma_req_r;
   logic        dma_valid;
   logic        dma_done_irq_r;
   logic        busy_r;
   logic [31:0] d;
   logic [255:0] iv;
   int          n_mismatch = 0;
   int          cmp_count = 0;

   // Expected digests of the block, one row per algorithm code
   localparam logic [0:2][255:0] DIG = {
      {160'hA9993E36_4706816A_BA3E2571_7850C26C_9CD0D89D, 96'h0},
      {224'h23097D22_3405D822_8642A477_BDA255B3_2AADBCE4_BDA0B3F7_E36C9DA7, 32'h0},
      256'hBA7816BF_8F01CFEA_414140DE_5DAE2223_B00361A3_96177A9C_B410FF61_F20015AD};
   localparam logic [0:2][3:0] NW = {4'h5, 4'h7, 4'h8};

   always #20 clk = ~clk;

   sha_engine #(.VERSION(32'h0000_0A5C)) sha_engine_inst  // Arbitrary version value
   (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .dma_req_r(dma_req_r),
      .dma_valid(dma_valid), .dma_data(dma_data), .dma_done_irq_r(dma_done_irq_r),
      .busy_r(busy_r)
   );

   sha_dma_src sha_dma_src_inst
   (
      .clk(clk), .sys_rst(sys_rst), .dma_req_r(dma_req_r), .dma_valid(dma_valid),
      .dma_data(dma_data), .slow(slow)
   );

   task finish_test;
   begin
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
   begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   end
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v);
   begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata_r;
   end
   endtask

   task load_block;
      int k;
   begin
      for (k = 0; k < 16; k++)
         wr(`SHA_OFF_MSG_BASE + 8'(4 * k), (k == 0) ? 32'h6162_6380 :
            (k == 15) ? 32'h0000_0018 : 32'h0000_0000);
   end
   endtask

   task wait_idle;
      int n;
   begin
      n = 0;
      @(posedge clk);
      #1;
      while (busy_r !== 1'b0 && n < 3000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 3000)
      begin
         n_mismatch++;
         finish_test;
      end
   end
   endtask

   task chk_dig(input int i, input int nw);
      int k;
   begin
      for (k = 0; k < nw; k++)
      begin
         rd(`SHA_OFF_HASH_BASE + 8'(4 * k), d);
         `CHK(d, DIG[i][255 - 32 * k -: 32])
      end
   end
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`SHA_OFF_ALG_SEL, d);   `CHK(d, 32'h0000_0000)
      rd(`SHA_OFF_HASH_BASE, d); `CHK(d, 32'h0000_0000)
      rd(`SHA_OFF_VERSION, d);   `CHK(d, 32'h0000_0A5C)
      rd(8'h30, d);              `CHK(d, 32'h0000_0000)
      `CHK({busy_r, dma_req_r, dma_done_irq_r}, 3'b000)
      // One row per algorithm, with prefetch and refused writes mid-run
      for (int i = 0; i < 3; i++)
      begin
         wr(`SHA_OFF_ALG_SEL, 32'(i));
         load_block;
         wr(`SHA_OFF_START, 32'h0000_0001);
         rd(`SHA_OFF_BUSY, d);
         `CHK(d != 32'h0000_0000, 1'b1)
         wr(`SHA_OFF_MSG_BASE, 32'hFFFF_FFFF);
         wr(`SHA_OFF_HASH_BASE, 32'h1234_5678);
         wr(`SHA_OFF_ALG_SEL, 32'((i + 1) % 3));
         wr(`SHA_OFF_START, 32'h0000_0001);
         wait_idle;
         rd(`SHA_OFF_BUSY, d);
         `CHK(d, 32'h0000_0000)
         chk_dig(i, NW[i]);
      end
      // Continue from restored state: SHA-224 code with SHA-256 start words
      iv = `SHA_IV256;
      wr(`SHA_OFF_ALG_SEL, 32'h0000_0001);
      for (int k = 0; k < 8; k++)
         wr(`SHA_OFF_HASH_BASE + 8'(4 * k), iv[255 - 32 * k -: 32]);
      rd(`SHA_OFF_HASH_BASE + 8'h1C, d);
      `CHK(d, iv[31:0])
      load_block;
      wr(`SHA_OFF_CONTINUE, 32'h0000_0001);
      wait_idle;
      chk_dig(2, 8);
      // DMA-fed runs
      wr(`SHA_OFF_IRQ_ENABLE, 32'h0000_0001);
      wr(`SHA_OFF_ALG_SEL, 32'h0000_0002);
      wr(`SHA_OFF_BLOCK_CNT, 32'h0000_0000);
      wr(`SHA_OFF_DMA_START, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1 `CHK(busy_r, 1'b0)
      wr(`SHA_OFF_BLOCK_CNT, 32'h0000_0001);
      slow <= 1'b1;
      wr(`SHA_OFF_DMA_START, 32'h0000_0001);
      wait_idle;
      `CHK(dma_done_irq_r, 1'b1)
      chk_dig(2, 8);
      wr(`SHA_OFF_IRQ_CLEAR, 32'h0000_0001);
      @(posedge clk);
      #1 `CHK(dma_done_irq_r, 1'b0)
      wr(`SHA_OFF_IRQ_ENABLE, 32'h0000_0000);
      slow <= 1'b0;
      wr(`SHA_OFF_DMA_START, 32'h0000_0001);
      wait_idle;
      `CHK(dma_done_irq_r, 1'b0)
      chk_dig(2, 8);
      // DMA continue from restored start words
      for (int k = 0; k < 8; k++)
         wr(`SHA_OFF_HASH_BASE + 8'(4 * k), iv[255 - 32 * k -: 32]);
      wr(`SHA_OFF_DMA_CONTINUE, 32'h0000_0001);
      wait_idle;
      chk_dig(2, 8);
      // Reset in mid-run
      wr(`SHA_OFF_START, 32'h0000_0001);
      repeat (5) @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      #1 `CHK(busy_r, 1'b0)
      rd(`SHA_OFF_HASH_BASE, d);
      `CHK(d, 32'h0000_0000)
      finish_test;
   end
endmodule // sha_engine_tb
`default_nettype wire
